//--- dv/ssr_spi_slave.sv
`timescale 1ns/1ps
module ssr_spi_slave #(
    parameter logic [7:0] REPLY = 8'h3C
) (
    input  wire logic sclk,
    input  wire logic mosi,
    input  wire logic cs_n,
    output logic      miso
);
    logic [31:0] tx_sh = '1;
    logic [31:0] rx    = '0;
    logic        out_r = 1'b0;
    // released line shows the inverse so a stale bit never passes as data;
    // one driver only, so a last fall and a deselect in one step cannot race
    assign miso = cs_n ? ~out_r : out_r;
    // mode 0: first bit ready at select, later bits after each fall
    always @(negedge cs_n)
    begin
        tx_sh <= {REPLY, 24'hFFFFFF};
        out_r <= REPLY[7];
    end
    always @(posedge sclk) if (!cs_n) rx <= {rx[30:0], mosi};
    always @(negedge sclk) if (!cs_n)
    begin
        out_r <= tx_sh[30];
        tx_sh <= {tx_sh[30:0], 1'b1};
    end
endmodule

//--- dv/tb_spi_data_status_irq_regs.sv
`timescale 1ns/1ps
module tb_spi_data_status_irq_regs;
    logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, rd, prdata;
    logic        pready, pslverr, sclk, mosi, cs_n, miso, irq, err;
    int          errors = 0, tests_run = 0;
    always #4 pclk = ~pclk;
    ssr_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .sclk(sclk), .mosi(mosi),
        .cs_n(cs_n), .miso(miso), .irq(irq));
    ssr_spi_slave peer_u (.sclk(sclk), .mosi(mosi), .cs_n(cs_n), .miso(miso));
    task automatic results;
        $display("errors=%0d tests_run=%0d", errors, tests_run);
        if (errors == 0 && tests_run > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, g, m);
        tests_run++;
        if ((g & m) !== (e & m))
        begin
            errors++;
            $display("CHECK FAILED %s exp %h got %h", nm, e & m, g & m);
        end
    endtask
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1; pwrite <= wr; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        do
        begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20)
        begin
            errors++;
            results();
        end
        rd = prdata; err = pslverr; psel <= 0; penable <= 0;
    endtask
    task automatic rdchk(input string nm, input logic [11:0] a, input logic [31:0] e, m);
        apb(0, a, 0);
        chk(nm, e, rd, m);
    endtask
    task automatic idle;
        int k;
        for (k = 0; k < 300; k++)
        begin
            apb(0, 12'h00C, 0);
            if (rd[4] === 1'b0) break;
        end
        if (k == 300)
        begin
            errors++;
            results();
        end
    endtask
    task automatic t_frame;
        int c, k;
        c = 0; k = 0;
        apb(1, 12'h010, 32'h4);
        rdchk("divisor", 12'h010, 32'h4, '1);
        apb(1, 12'h000, 32'h80027);
        apb(1, 12'h008, 32'h1A5);
        rdchk("busy", 12'h00C, 32'h10, 32'h10);
        // sampled off the edge that moves the serial clock
        while (sclk !== 1'b0 && k < 99) begin @(negedge pclk); k++; end
        while (sclk !== 1'b1 && k < 99) begin @(negedge pclk); k++; end
        while (sclk !== 1'b0 && c < 99) begin @(negedge pclk); c++; end
        while (sclk !== 1'b1 && c < 99) begin @(negedge pclk); c++; end
        chk("sclk seen", 1, k < 99, 1);
        chk("bit period", 8, c, '1);
        idle();
        chk("mosi word", 32'hA5, peer_u.rx, 32'hFF);
        rdchk("rx word", 12'h008, 32'h3C, '1);
        rdchk("popped", 12'h00C, 32'h3, '1);
    endtask
    task automatic t_over;
        apb(1, 12'h010, 32'h2);
        apb(1, 12'h000, 32'h84007);
        for (int i = 0; i < 9; i++) apb(1, 12'h008, i);
        idle();
        repeat (150) @(posedge pclk);
        rdchk("rx full", 12'h00C, 32'hC, 32'hC);
        rdchk("raw", 12'h018, 32'h27, 32'h3F);
        chk("irq masked", 0, irq, 1);
        apb(1, 12'h014, 32'h1);
        repeat (2) @(posedge pclk);
        chk("irq on", 1, irq, 1);
        rdchk("masked", 12'h01C, 32'h1, 32'h3F);
        apb(1, 12'h020, 32'h1);
        rdchk("raw clear", 12'h018, 0, 1);
        repeat (2) @(posedge pclk);
        chk("irq off", 0, irq, 1);
        apb(0, 12'h008, 0);
        rdchk("level 7", 12'h018, 0, 32'h4);
        for (int i = 0; i < 7; i++) apb(0, 12'h008, 0);
        rdchk("rx empty", 12'h00C, 32'h3, 32'hF);
        apb(1, 12'h014, 0);
    endtask
    task automatic t_txfull;
        apb(1, 12'h000, 32'h7);
        for (int i = 0; i < 9; i++) apb(1, 12'h008, i);
        rdchk("tx full", 12'h00C, 32'h10, 32'h13);
        // stream mode: the last frame ends on an empty fifo and must flag underrun
        apb(1, 12'h000, 32'h180007);
        idle();
        rdchk("tx drained", 12'h00C, 32'h3, 32'h3);
        rdchk("underrun", 12'h018, 32'h10, 32'h10);
        apb(1, 12'h020, 32'h4);
        rdchk("tur clear", 12'h018, 0, 32'h10);
    endtask
    initial
    begin
        repeat (6) @(posedge pclk);
        presetn <= 1;
        rdchk("status rst", 12'h00C, 32'h3, '1);
        rdchk("mask rst", 12'h014, 0, '1);
        rdchk("raw rst", 12'h018, 0, 32'h1F);
        apb(0, 12'h004, 0);
        chk("slverr", 1, err, 1);
        t_frame();
        t_over();
        t_txfull();
        results();
    end
endmodule

//--- hw/ssr_fifo.sv
`timescale 1ns/1ps
module ssr_fifo (
    input  wire logic                        pclk,
    input  wire logic                        presetn,
    input  wire logic                        push,
    input  wire logic [ssr_pkg::DATA_W-1:0]  push_data,
    input  wire logic                        pop,
    output logic      [ssr_pkg::DATA_W-1:0]  head,
    output logic      [ssr_pkg::CNT_W-1:0]   count,
    output logic                             full,
    output logic                             empty
);
    logic [ssr_pkg::DATA_W-1:0] mem [ssr_pkg::FIFO_DEPTH];
    logic [ssr_pkg::PTR_W-1:0]  wr_ptr_r;
    logic [ssr_pkg::PTR_W-1:0]  rd_ptr_r;
    logic [ssr_pkg::CNT_W-1:0]  cnt_r;
    logic                       do_push;
    logic                       do_pop;

    assign full    = (cnt_r == ssr_pkg::CNT_W'(ssr_pkg::FIFO_DEPTH));
    assign empty   = (cnt_r == '0);
    // a push into a full fifo is dropped; the caller flags it on the receive side only
    assign do_push = push && !full;
    assign do_pop  = pop && !empty;
    assign head    = mem[rd_ptr_r];
    assign count   = cnt_r;

    always_ff @(posedge pclk)
    begin
        if (do_push)
            mem[wr_ptr_r] <= push_data;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            cnt_r    <= '0;
        end
        else
        begin
            if (do_push)
                wr_ptr_r <= wr_ptr_r + 1'b1;
            if (do_pop)
                rd_ptr_r <= rd_ptr_r + 1'b1;
            if (do_push && !do_pop)
                cnt_r <= cnt_r + 1'b1;
            else if (do_pop && !do_push)
                cnt_r <= cnt_r - 1'b1;
        end
    end
endmodule

//--- hw/ssr_pkg.sv
package ssr_pkg;
    localparam int          DATA_W     = 32;
    localparam int          PADDR_W    = 12;
    localparam int          FIFO_DEPTH = 8;
    localparam int          PTR_W      = 3;
    localparam int          CNT_W      = 4;
    localparam int          N_IRQ      = 6;

    // register byte offsets
    localparam logic [11:0] OFF_CFG    = 12'h000;
    localparam logic [11:0] OFF_DATA   = 12'h008;
    localparam logic [11:0] OFF_STAT   = 12'h00C;
    localparam logic [11:0] OFF_PRESC  = 12'h010;
    localparam logic [11:0] OFF_MASK   = 12'h014;
    localparam logic [11:0] OFF_RAW    = 12'h018;
    localparam logic [11:0] OFF_MIS    = 12'h01C;
    localparam logic [11:0] OFF_ICR    = 12'h020;

    // fifo_status bits
    localparam int          ST_TFE     = 0;
    localparam int          ST_TNF     = 1;
    localparam int          ST_RNE     = 2;
    localparam int          ST_RFF     = 3;
    localparam int          ST_BSY     = 4;

    // interrupt source bits
    localparam int          IRQ_ROR    = 0;
    localparam int          IRQ_RT     = 1;
    localparam int          IRQ_RX     = 2;
    localparam int          IRQ_TX     = 3;
    localparam int          IRQ_TUR    = 4;
    localparam int          IRQ_TE     = 5;

    // interrupt clear bits
    localparam int          ICR_ROR    = 0;
    localparam int          ICR_RT     = 1;
    localparam int          ICR_TUR    = 2;

    // fifo trigger level codes and thresholds
    localparam logic [2:0]  LVL_SEL_1  = 3'h0;
    localparam logic [2:0]  LVL_SEL_4  = 3'h1;
    localparam logic [2:0]  LVL_SEL_8  = 3'h2;
    localparam logic [3:0]  LVL_1      = 4'h1;
    localparam logic [3:0]  LVL_4      = 4'h4;
    localparam logic [3:0]  LVL_8      = 4'h8;

    localparam logic [7:0]  MIN_DIV    = 8'h02;
    localparam logic [7:0]  PRESC_RST  = 8'h00;
    localparam logic [5:0]  MASK_RST   = 6'h00;

    // receive timeout: least time, rounded up to cycles
    localparam int          CLK_NS     = 8;
    localparam int          TMO_NS     = 1024;
    localparam int          TMO_CYC    = (TMO_NS + CLK_NS - 1) / CLK_NS;
    localparam logic [7:0]  TMO_LAST   = 8'(TMO_CYC - 1);

    typedef struct packed {
        logic       stream;
        logic       en;
        logic [2:0] tx_sel;
        logic [2:0] rx_sel;
        logic [7:0] serial_clock_rate_factor;
        logic [4:0] size_m1;
    } ssr_cfg_s;

    localparam int          CFG_W      = $bits(ssr_cfg_s);
    localparam ssr_cfg_s    CFG_RST    = '{stream: 1'b0, en: 1'b0, tx_sel: 3'h0,
                                           rx_sel: 3'h0, serial_clock_rate_factor: 8'h00, size_m1: 5'h07};

    typedef enum logic {ENG_IDLE, ENG_SHIFT} ssr_eng_e;
    typedef logic [N_IRQ-1:0] ssr_irq_t;
endpackage

//--- hw/ssr_top.sv
// Decided for this implementation: the APB interface to the registers.
`timescale 1ns/1ps
module ssr_top (
    input  wire logic                          pclk,
    input  wire logic                          presetn,
    input  wire logic                          psel,
    input  wire logic                          penable,
    input  wire logic                          pwrite,
    input  wire logic [ssr_pkg::PADDR_W-1:0]   paddr,
    input  wire logic [ssr_pkg::DATA_W-1:0]    pwdata,
    output logic      [ssr_pkg::DATA_W-1:0]    prdata,
    output logic                               pready,
    output logic                               pslverr,
    output logic                               sclk,
    output logic                               mosi,
    output logic                               cs_n,
    input  wire logic                          miso,
    output logic                               irq
);
    function automatic logic [3:0] lvl_thresh(input logic [2:0] sel);
        logic [3:0] t;
        t = ssr_pkg::LVL_1;
        unique case (sel)
            ssr_pkg::LVL_SEL_1: t = ssr_pkg::LVL_1;
            ssr_pkg::LVL_SEL_4: t = ssr_pkg::LVL_4;
            ssr_pkg::LVL_SEL_8: t = ssr_pkg::LVL_8;
            // reserved codes fall back to the lowest level
            default:            t = ssr_pkg::LVL_1;
        endcase
        return t;
    endfunction

    function automatic logic mapped(input logic [ssr_pkg::PADDR_W-1:0] a);
        return (a == ssr_pkg::OFF_CFG)   || (a == ssr_pkg::OFF_DATA) ||
               (a == ssr_pkg::OFF_STAT)  || (a == ssr_pkg::OFF_PRESC) ||
               (a == ssr_pkg::OFF_MASK)  || (a == ssr_pkg::OFF_RAW) ||
               (a == ssr_pkg::OFF_MIS)   || (a == ssr_pkg::OFF_ICR);
    endfunction

    ssr_pkg::ssr_cfg_s          cfg_r;
    ssr_pkg::ssr_eng_e          state_r;
    ssr_pkg::ssr_irq_t          raw;
    ssr_pkg::ssr_irq_t          mis;
    logic [7:0]                 presc_r;
    logic [5:0]                 mask_r;
    logic [ssr_pkg::DATA_W-1:0] prdata_r;
    logic                       ovr_r;
    logic                       tmo_r;
    logic                       tur_r;
    logic                       irq_r;
    logic [7:0]                 tmo_cnt_r;
    logic [15:0]                pre_cnt_r;
    logic [4:0]                 bit_r;
    logic [ssr_pkg::DATA_W-1:0] tx_sh_r;
    logic [ssr_pkg::DATA_W-1:0] rx_sh_r;
    logic                       sclk_r;
    logic                       mosi_r;
    logic                       cs_n_r;

    logic                       setup_rd;
    logic                       acc_wr;
    logic                       acc_rd;
    logic                       tx_push;
    logic                       tx_pop;
    logic                       rx_push;
    logic                       rx_pop;
    logic [ssr_pkg::DATA_W-1:0] tx_head;
    logic [ssr_pkg::DATA_W-1:0] rx_head;
    logic [ssr_pkg::DATA_W-1:0] rx_word;
    logic [ssr_pkg::DATA_W-1:0] fmask;
    logic [ssr_pkg::CNT_W-1:0]  tx_cnt;
    logic [ssr_pkg::CNT_W-1:0]  rx_cnt;
    logic                       tx_full;
    logic                       tx_empty;
    logic                       rx_full;
    logic                       rx_empty;
    logic                       busy;
    logic                       start;
    logic                       tick;
    logic                       frame_done;
    logic                       ovr_set;
    logic                       tmo_set;
    logic                       tur_set;
    logic [7:0]                 div_eff;
    logic [16:0]                period;
    logic [15:0]                half;
    logic [ssr_pkg::DATA_W-1:0] stat_word;

    // zero-wait slave: access phase always completes in its first cycle
    assign pready   = 1'b1;
    assign pslverr  = psel && penable && !mapped(paddr);
    assign prdata   = prdata_r;
    assign setup_rd = psel && !penable && !pwrite;
    assign acc_wr   = psel && penable && pwrite;
    assign acc_rd   = psel && penable && !pwrite;
    assign sclk     = sclk_r;
    assign mosi     = mosi_r;
    assign cs_n     = cs_n_r;
    assign irq      = irq_r;

    assign tx_push  = acc_wr && (paddr == ssr_pkg::OFF_DATA);
    assign rx_pop   = acc_rd && (paddr == ssr_pkg::OFF_DATA);

    ssr_fifo u_tx_fifo (
        .pclk      (pclk),
        .presetn   (presetn),
        .push      (tx_push),
        .push_data (pwdata),
        .pop       (tx_pop),
        .head      (tx_head),
        .count     (tx_cnt),
        .full      (tx_full),
        .empty     (tx_empty)
    );

    ssr_fifo u_rx_fifo (
        .pclk      (pclk),
        .presetn   (presetn),
        .push      (rx_push),
        .push_data (rx_word),
        .pop       (rx_pop),
        .head      (rx_head),
        .count     (rx_cnt),
        .full      (rx_full),
        .empty     (rx_empty)
    );

    assign busy = (state_r == ssr_pkg::ENG_SHIFT) || !tx_empty;

    always_comb
    begin
        stat_word                  = '0;
        stat_word[ssr_pkg::ST_TFE] = tx_empty;
        stat_word[ssr_pkg::ST_TNF] = !tx_full;
        stat_word[ssr_pkg::ST_RNE] = !rx_empty;
        stat_word[ssr_pkg::ST_RFF] = rx_full;
        stat_word[ssr_pkg::ST_BSY] = busy;
    end

    always_comb
    begin
        raw                   = '0;
        raw[ssr_pkg::IRQ_ROR] = ovr_r;
        raw[ssr_pkg::IRQ_RT]  = tmo_r;
        raw[ssr_pkg::IRQ_RX]  = rx_cnt >= lvl_thresh(cfg_r.rx_sel);
        raw[ssr_pkg::IRQ_TX]  = tx_cnt >= lvl_thresh(cfg_r.tx_sel);
        raw[ssr_pkg::IRQ_TUR] = tur_r;
        raw[ssr_pkg::IRQ_TE]  = tx_empty;
    end

    assign mis = raw & mask_r;

    // read data is captured in the setup cycle so prdata comes from a flop
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata_r <= '0;
        else if (setup_rd)
        begin
            unique case (paddr)
                ssr_pkg::OFF_CFG:   prdata_r <= 32'(cfg_r);
                ssr_pkg::OFF_DATA:  prdata_r <= rx_empty ? '0 : rx_head;
                ssr_pkg::OFF_STAT:  prdata_r <= stat_word;
                ssr_pkg::OFF_PRESC: prdata_r <= 32'(presc_r);
                ssr_pkg::OFF_MASK:  prdata_r <= 32'(mask_r);
                ssr_pkg::OFF_RAW:   prdata_r <= 32'(raw);
                ssr_pkg::OFF_MIS:   prdata_r <= 32'(mis);
                default:            prdata_r <= '0;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cfg_r   <= ssr_pkg::CFG_RST;
            presc_r <= ssr_pkg::PRESC_RST;
            mask_r  <= ssr_pkg::MASK_RST;
        end
        else if (acc_wr)
        begin
            if (paddr == ssr_pkg::OFF_CFG)
                cfg_r <= ssr_pkg::ssr_cfg_s'(pwdata[ssr_pkg::CFG_W-1:0]);
            if (paddr == ssr_pkg::OFF_PRESC)
                presc_r <= pwdata[7:0];
            if (paddr == ssr_pkg::OFF_MASK)
                mask_r <= pwdata[ssr_pkg::N_IRQ-1:0];
        end
    end

    // divisor below the legal minimum is run as the minimum; an odd
    // period (divisor times one more than the rate factor) loses its low bit in the half period
    assign div_eff = (presc_r < ssr_pkg::MIN_DIV) ? ssr_pkg::MIN_DIV : presc_r;
    assign period  = 17'(div_eff) * (17'(cfg_r.serial_clock_rate_factor) + 17'h1);
    assign half    = period[16:1];
    assign tick    = (state_r == ssr_pkg::ENG_SHIFT) && (pre_cnt_r == half - 16'h1);

    assign start      = (state_r == ssr_pkg::ENG_IDLE) && cfg_r.en && !tx_empty;
    assign tx_pop     = start;
    assign frame_done = tick && sclk_r && (bit_r == '0);
    assign fmask      = 32'hFFFFFFFF >> (5'h1F - cfg_r.size_m1);
    assign rx_word    = rx_sh_r & fmask;
    assign rx_push    = frame_done && !rx_full;
    assign ovr_set    = frame_done && rx_full;
    // a stream that runs dry between frames counts as underrun
    assign tur_set    = frame_done && cfg_r.stream && tx_empty;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            pre_cnt_r <= '0;
        else if (state_r != ssr_pkg::ENG_SHIFT || tick)
            pre_cnt_r <= '0;
        else
            pre_cnt_r <= pre_cnt_r + 16'h1;
    end

    // mode 0 master: sample on rising edge, drive on falling edge;
    // changing the frame size mid-frame corrupts that frame
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_r <= ssr_pkg::ENG_IDLE;
            sclk_r  <= 1'b0;
            cs_n_r  <= 1'b1;
            mosi_r  <= 1'b0;
            bit_r   <= '0;
            tx_sh_r <= '0;
            rx_sh_r <= '0;
        end
        else
        begin
            unique case (state_r)
                ssr_pkg::ENG_IDLE:
                begin
                    if (start)
                    begin
                        state_r <= ssr_pkg::ENG_SHIFT;
                        cs_n_r  <= 1'b0;
                        tx_sh_r <= tx_head;
                        bit_r   <= cfg_r.size_m1;
                        mosi_r  <= tx_head[cfg_r.size_m1];
                        rx_sh_r <= '0;
                    end
                end
                ssr_pkg::ENG_SHIFT:
                begin
                    if (tick)
                    begin
                        sclk_r <= !sclk_r;
                        if (!sclk_r)
                            rx_sh_r <= {rx_sh_r[ssr_pkg::DATA_W-2:0], miso};
                        else if (bit_r == '0)
                        begin
                            state_r <= ssr_pkg::ENG_IDLE;
                            cs_n_r  <= 1'b1;
                        end
                        else
                        begin
                            bit_r  <= bit_r - 5'h1;
                            mosi_r <= tx_sh_r[bit_r - 5'h1];
                        end
                    end
                end
            endcase
        end
    end

    assign tmo_set = (tmo_cnt_r == ssr_pkg::TMO_LAST) && !rx_empty && !rx_pop;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            tmo_cnt_r <= '0;
        else if (rx_empty || rx_pop)
            tmo_cnt_r <= '0;
        else if (tmo_cnt_r != ssr_pkg::TMO_LAST)
            tmo_cnt_r <= tmo_cnt_r + 8'h1;
    end

    // sticky sources: a set in the same cycle as a clear wins
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ovr_r <= 1'b0;
            tmo_r <= 1'b0;
            tur_r <= 1'b0;
        end
        else
        begin
            ovr_r <= ovr_set || (ovr_r && !(acc_wr && paddr == ssr_pkg::OFF_ICR
                                            && pwdata[ssr_pkg::ICR_ROR]));
            tmo_r <= tmo_set || (tmo_r && !(acc_wr && paddr == ssr_pkg::OFF_ICR
                                            && pwdata[ssr_pkg::ICR_RT]));
            tur_r <= tur_set || (tur_r && !(acc_wr && paddr == ssr_pkg::OFF_ICR
                                            && pwdata[ssr_pkg::ICR_TUR]));
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            irq_r <= 1'b0;
        else
            irq_r <= |mis;
    end

    logic [15:0] gap_r;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            gap_r <= 16'h1;
        // restarts on the toggle edge itself so every half period counts alike
        else if (state_r != ssr_pkg::ENG_SHIFT || tick)
            gap_r <= 16'h1;
        else
            gap_r <= gap_r + 16'h1;
    end

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    dr_pop_a: assert property (
        rx_pop && !rx_empty && !rx_push |=> rx_cnt == $past(rx_cnt) - 4'h1)
        else $error("data read did not pop receive fifo");
    dr_push_a: assert property (
        tx_push && !tx_full && !tx_pop |=> tx_cnt == $past(tx_cnt) + 4'h1)
        else $error("data write did not push transmit fifo");
    rx_align_a: assert property (
        rx_push |-> (33'(rx_word) >> (6'(cfg_r.size_m1) + 6'h1)) == 33'h0)
        else $error("receive word not right-justified");
    stat_tx_a: assert property (
        setup_rd && paddr == ssr_pkg::OFF_STAT |=>
        prdata_r[ssr_pkg::ST_TFE] == $past(tx_empty) && prdata_r[ssr_pkg::ST_TNF] == !$past(tx_full))
        else $error("transmit status bits wrong");
    stat_rx_a: assert property (
        setup_rd && paddr == ssr_pkg::OFF_STAT |=>
        prdata_r[ssr_pkg::ST_RNE] == !$past(rx_empty) && prdata_r[ssr_pkg::ST_RFF] == $past(rx_full))
        else $error("receive status bits wrong");
    busy_flag_a: assert property (
        setup_rd && paddr == ssr_pkg::OFF_STAT && state_r == ssr_pkg::ENG_SHIFT
        |=> prdata_r[ssr_pkg::ST_BSY])
        else $error("busy flag low while shifting");
    bit_rate_a: assert property (
        $changed(sclk_r) |-> $past(gap_r) == $past(half))
        else $error("serial clock half period wrong");
    mask_wr_a: assert property (
        acc_wr && paddr == ssr_pkg::OFF_MASK |=> mask_r == $past(pwdata[5:0]))
        else $error("mask register not written");
    overrun_set_a: assert property (
        frame_done && rx_full |=> ovr_r && rx_full)
        else $error("overrun not raised");
    timeout_set_a: assert property (
        tmo_cnt_r == ssr_pkg::TMO_LAST && !rx_empty && !rx_pop |=> tmo_r)
        else $error("timeout not raised");
    raw_read_a: assert property (
        setup_rd && paddr == ssr_pkg::OFF_RAW |=> prdata_r[5:0] == $past(raw))
        else $error("raw status read wrong");
    rx_level_a: assert property (
        cfg_r.rx_sel == ssr_pkg::LVL_SEL_4 && rx_cnt == 4'h3 |-> !raw[ssr_pkg::IRQ_RX])
        else $error("receive level fired below threshold");
    mis_read_a: assert property (
        setup_rd && paddr == ssr_pkg::OFF_MIS |=> prdata_r[5:0] == ($past(raw) & $past(mask_r)))
        else $error("masked status read wrong");
    ovr_clear_a: assert property (
        acc_wr && paddr == ssr_pkg::OFF_ICR && pwdata[ssr_pkg::ICR_ROR] && !ovr_set |=> !ovr_r)
        else $error("overrun not cleared");
    irq_out_a: assert property (
        |(raw & mask_r) |=> irq_r)
        else $error("interrupt output not raised");
endmodule
